// ==== logic/ira_pkg.sv ====
`default_nettype none
package ira_pkg;
    // Access window timing at the 40 MHz device clock
    localparam int unsigned CLK_FREQ_MHZ   = 40;
    localparam int unsigned ACCESS_TIME_NS = 900;
    // Longest time, so rounded down
    localparam int unsigned ACCESS_CYCLES  = ACCESS_TIME_NS * CLK_FREQ_MHZ / 1000;
    // Pin sync and edge detect use part of the budget before commit
    localparam int unsigned SYNC_CYCLES    = 3;
    localparam logic [5:0]  ACCESS_LAST    = 6'(ACCESS_CYCLES - SYNC_CYCLES - 1);

    localparam logic        SEL_DIRECT = 1'b0;
    localparam logic        SEL_WINDOW = 1'b1;

    localparam logic [1:0]  POS_CTRL = 2'h0;
    localparam logic [1:0]  POS_DATA = 2'h1;
    localparam logic [1:0]  POS_ADDR = 2'h2;

    localparam int          KIND_HI     = 5;
    localparam int          KIND_LO     = 4;
    localparam int          DIR_BIT     = 0;
    localparam logic [1:0]  KIND_REG    = 2'h3;
    localparam logic [1:0]  KIND_CM_RD  = 2'h0;
    localparam logic [7:0]  CTRL_UNUSED = 8'hcc;

    localparam logic [7:0]  ADDR_CONFIG      = 8'hfe;
    localparam logic [7:0]  ADDR_FRAME_SHIFT = 8'hff;

    localparam int          STAT_MEMRST_BIT = 7;
    localparam int          STAT_BUSY_BIT   = 6;
    localparam int          STAT_LOSS_BIT   = 5;

    localparam int          MODE_ABORT_BIT  = 0;
    localparam logic [7:0]  MODE_RESET      = 8'h00;
    localparam int          CFG_STD_BIT     = 0;
    localparam logic [1:0]  CFG_RESET       = 2'h1;
    localparam logic [5:0]  CFG_READ_ONES   = 6'h3f;
    localparam logic [7:0]  FS_RESET        = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_COLLECT,
        ST_EXEC,
        ST_READBACK,
        ST_RELEASE
    } seq_state_t;
endpackage
`default_nettype wire

// ==== logic/connection_memory.sv ====
`timescale 1ns/1ps
`default_nettype none
module connection_memory
(
    input  wire logic       i_clk,    // Device clock
    input  wire logic       i_rst_n,  // Synchronised reset
    input  wire logic       i_we,     // Write strobe
    input  wire logic [7:0] i_addr_a, // Host side address
    input  wire logic [9:0] i_wdata,  // Write word
    output logic      [9:0] o_rdata_a,// Host side read word
    input  wire logic [7:0] i_addr_b, // Switching side address
    output logic      [9:0] o_rdata_b // Switching side word
);
    // No reset on the array itself, only on the read registers
    logic [9:0] mem [256];

    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem[i_addr_a] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata_a <= 10'h000;
            o_rdata_b <= 10'h000;
        end
        else
        begin
            o_rdata_a <= mem[i_addr_a];
            o_rdata_b <= mem[i_addr_b];
        end
    end
endmodule // connection_memory
`default_nettype wire

// ==== logic/indirect_register_access.sv ====
// Contract
// RQ1 - Host uses three window transfers per access
// RQ2 - Transfers are control, data, address in turn
// RQ3 - Host starts only with both busy flags clear
// RQ4 - First transfer sets indirect busy flag
// RQ5 - Access done within 900 ns, busy cleared
// RQ6 - Host idles both strobes between transfers
// RQ7 - Direct registers stay usable mid sequence
// RQ8 - Abort bit cancels a running sequence
// RQ9 - Kind bits select register, memory read, write
// RQ10 - Direction bit zero writes, spare bit ignored
// RQ11 - Address fe configuration, ff frame shift
// RQ12 - Memory word is control low bits plus data
// RQ13 - Host reads by request then three reads
// RQ14 - Result lands in data byte within 900 ns
// RQ15 - Read back sets busy, returns three bytes
// RQ16 - Up to 900 ns release after third read
// RQ17 - Unused control bits read back as one
// RQ18 - Host writes unused control bits as zero
// RQ19 - Register read back shows control low ones
// RQ20 - Status has three flags, low five zero
// RQ21 - Frame shift held zero in standard setup
// RQ22 - Configuration reads top six bits as one
// RQ23 - Select low is setup or flags, high window
// RQ24 - Strobes ignored while device select high
// RQ25 - Transfer counter returns to first position
`timescale 1ns/1ps
`default_nettype none
module indirect_register_access
(
    input  wire logic       i_mclk,                // 40 MHz device clock
    input  wire logic       i_arst_n,              // Async reset, active low
    input  wire logic       i_cs_n,                // Device select pin
    input  wire logic       i_wr_n,                // Store strobe pin
    input  wire logic       i_rd_n,                // Fetch strobe pin
    input  wire logic       i_register_select_line,// Window or direct select
    input  wire logic [7:0] i_db,                  // Data bus in
    output logic      [7:0] o_db,                  // Data bus out
    output logic            o_db_oe,               // Data bus drive enable
    input  wire logic       i_mem_reset_busy,      // Memory reset in progress
    input  wire logic       i_data_loss,           // Data loss warning
    output logic      [7:0] o_mode,                // Operation setup value
    output logic      [1:0] o_config,              // Configuration value
    output logic      [7:0] o_frame_shift,         // Frame shift value
    output logic            o_busy,                // Indirect busy flag
    input  wire logic [7:0] i_cm_rd_addr,          // Switching read address
    output logic      [9:0] o_cm_word              // Switching read word
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  rst_q;
    logic        rst_n;
    logic [11:0] pin_m;
    logic [11:0] pin_s;

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_q <= 2'h0;
        end
        else
        begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Pins are asynchronous to the device clock
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_m <= 12'he00;
            pin_s <= 12'he00;
        end
        else
        begin
            pin_m <= {i_cs_n, i_wr_n, i_rd_n, i_register_select_line, i_db};
            pin_s <= pin_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic        wr_act;
    logic        rd_act;
    logic        wr_act_q;
    logic        rd_act_q;
    logic        wr_end;
    logic        rd_start;
    logic        rd_end;
    logic        sel_s;
    logic [7:0]  db_s;

    // Strobes only count while device is selected
    // RQ24 select gates strobes
    assign wr_act   = ~pin_s[11] & ~pin_s[10];
    assign rd_act   = ~pin_s[11] & ~pin_s[9];
    assign sel_s    = pin_s[8];
    assign db_s     = pin_s[7:0];
    // Write commits at strobe end, when bus data has long settled
    assign wr_end   = wr_act_q & ~wr_act;
    assign rd_start = rd_act & ~rd_act_q;
    assign rd_end   = rd_act_q & ~rd_act;

    ////////////////////////////////////////////////////////////////////////
    ira_pkg::seq_state_t state;
    ira_pkg::seq_state_t next_state;
    logic [1:0]  pos;
    logic [1:0]  next_pos;
    logic [5:0]  cnt;
    logic [5:0]  next_cnt;
    logic        busy;
    logic        next_busy;
    logic [7:0]  win_ctrl;
    logic [7:0]  next_win_ctrl;
    logic [7:0]  win_data;
    logic [7:0]  next_win_data;
    logic [7:0]  win_addr;
    logic [7:0]  next_win_addr;
    logic [7:0]  mode;
    logic [7:0]  next_mode;
    logic [1:0]  cfg;
    logic [1:0]  next_cfg;
    logic [7:0]  fs;
    logic [7:0]  next_fs;
    logic [7:0]  wr_data;
    logic [7:0]  next_wr_data;
    logic        wr_sel;
    logic        next_wr_sel;
    logic        rd_sel;
    logic        next_rd_sel;
    logic [7:0]  dbo;
    logic [7:0]  next_dbo;
    logic        dbo_oe;
    logic        cm_we;
    logic [9:0]  cm_q;
    logic [1:0]  kind;
    logic        abort;
    logic        standard;
    logic        reg_read;
    logic [7:0]  ctrl_rb;
    logic [7:0]  status;

    assign kind     = win_ctrl[ira_pkg::KIND_HI:ira_pkg::KIND_LO];
    assign abort    = mode[ira_pkg::MODE_ABORT_BIT];
    assign standard = cfg[ira_pkg::CFG_STD_BIT];
    // RQ10 direction bit only
    assign reg_read = win_ctrl[ira_pkg::DIR_BIT];

    // RQ17 unused bits read one
    // RQ19 register low bits one
    always_comb
    begin
        ctrl_rb = win_ctrl | ira_pkg::CTRL_UNUSED;
        if (kind == ira_pkg::KIND_REG)
        begin
            ctrl_rb[1:0] = 2'h3;
        end
    end

    // RQ20 three flags, rest zero
    always_comb
    begin
        status = 8'h00;
        status[ira_pkg::STAT_MEMRST_BIT] = i_mem_reset_busy;
        status[ira_pkg::STAT_BUSY_BIT]   = busy;
        status[ira_pkg::STAT_LOSS_BIT]   = i_data_loss;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state    = state;
        next_pos      = pos;
        next_cnt      = cnt;
        next_busy     = busy;
        next_win_ctrl = win_ctrl;
        next_win_data = win_data;
        next_win_addr = win_addr;
        next_mode     = mode;
        next_cfg      = cfg;
        next_fs       = fs;
        next_wr_data  = wr_data;
        next_wr_sel   = wr_sel;
        next_rd_sel   = rd_sel;
        next_dbo      = dbo;
        cm_we         = 1'b0;
        if (wr_act)
        begin
            next_wr_data = db_s;
            next_wr_sel  = sel_s;
        end
        // RQ23 select picks register
        if (rd_start)
        begin
            next_rd_sel = sel_s;
            if (sel_s == ira_pkg::SEL_DIRECT)
            begin
                next_dbo = status;
            end
            else
            begin
                unique case (pos)
                    ira_pkg::POS_CTRL: next_dbo = ctrl_rb;
                    ira_pkg::POS_DATA: next_dbo = win_data;
                    default:           next_dbo = win_addr;
                endcase
            end
        end
        // RQ7 direct write any time
        if (wr_end && wr_sel == ira_pkg::SEL_DIRECT)
        begin
            next_mode = wr_data;
        end
        unique case (state)
            ira_pkg::ST_IDLE:
            begin
                // RQ4 busy on first write
                if (wr_end && wr_sel == ira_pkg::SEL_WINDOW)
                begin
                    next_win_ctrl = wr_data;
                    next_pos      = ira_pkg::POS_DATA;
                    next_busy     = 1'b1;
                    next_state    = ira_pkg::ST_COLLECT;
                end
                // RQ15 busy on first read
                else if (rd_start && sel_s == ira_pkg::SEL_WINDOW)
                begin
                    next_busy  = 1'b1;
                    next_state = ira_pkg::ST_READBACK;
                end
            end
            ira_pkg::ST_COLLECT:
            begin
                // RQ2 byte order
                if (wr_end && wr_sel == ira_pkg::SEL_WINDOW)
                begin
                    if (pos == ira_pkg::POS_DATA)
                    begin
                        next_win_data = wr_data;
                        next_pos      = ira_pkg::POS_ADDR;
                    end
                    else
                    begin
                        next_win_addr = wr_data;
                        next_pos      = ira_pkg::POS_CTRL;
                        next_cnt      = 6'h00;
                        next_state    = ira_pkg::ST_EXEC;
                    end
                end
            end
            ira_pkg::ST_EXEC:
            begin
                next_cnt = cnt + 6'h01;
                // RQ9 kind decode
                if (cnt == 6'h00)
                begin
                    if (kind == ira_pkg::KIND_REG)
                    begin
                        // RQ11 fe and ff select
                        if (!reg_read && win_addr == ira_pkg::ADDR_CONFIG)
                        begin
                            next_cfg = win_data[1:0];
                        end
                        if (!reg_read && win_addr == ira_pkg::ADDR_FRAME_SHIFT)
                        begin
                            next_fs = win_data;
                        end
                        // RQ22 top six bits one
                        if (reg_read && win_addr == ira_pkg::ADDR_CONFIG)
                        begin
                            next_win_data = {ira_pkg::CFG_READ_ONES, cfg};
                        end
                        if (reg_read && win_addr == ira_pkg::ADDR_FRAME_SHIFT)
                        begin
                            next_win_data = fs;
                        end
                    end
                    // RQ12 ten bit word
                    else if (kind != ira_pkg::KIND_CM_RD)
                    begin
                        cm_we = 1'b1;
                    end
                end
                // RQ14 memory result placed
                if (cnt == 6'h01 && kind == ira_pkg::KIND_CM_RD)
                begin
                    next_win_data      = cm_q[7:0];
                    next_win_ctrl[1:0] = cm_q[9:8];
                end
                // RQ5 done within 900 ns
                if (cnt == ira_pkg::ACCESS_LAST)
                begin
                    next_busy  = 1'b0;
                    next_state = ira_pkg::ST_IDLE;
                end
            end
            ira_pkg::ST_READBACK:
            begin
                if (rd_end && rd_sel == ira_pkg::SEL_WINDOW)
                begin
                    next_pos = pos + 2'h1;
                    if (pos == ira_pkg::POS_ADDR)
                    begin
                        next_pos   = ira_pkg::POS_CTRL;
                        next_cnt   = 6'h00;
                        next_state = ira_pkg::ST_RELEASE;
                    end
                end
            end
            ira_pkg::ST_RELEASE:
            begin
                next_cnt = cnt + 6'h01;
                // RQ16 release within 900 ns
                if (cnt == ira_pkg::ACCESS_LAST)
                begin
                    next_busy  = 1'b0;
                    next_state = ira_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = ira_pkg::ST_IDLE;
            end
        endcase
        // RQ8 abort cancels
        // RQ25 counter back to first
        if (abort)
        begin
            next_state = ira_pkg::ST_IDLE;
            next_pos   = ira_pkg::POS_CTRL;
            next_cnt   = 6'h00;
            next_busy  = 1'b0;
        end
        // RQ21 zero in standard setup
        if (standard)
        begin
            next_fs = 8'h00;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= ira_pkg::ST_IDLE;
            pos      <= ira_pkg::POS_CTRL;
            cnt      <= 6'h00;
            busy     <= 1'b0;
            win_ctrl <= 8'h00;
            win_data <= 8'h00;
            win_addr <= 8'h00;
            mode     <= ira_pkg::MODE_RESET;
            cfg      <= ira_pkg::CFG_RESET;
            fs       <= ira_pkg::FS_RESET;
            wr_data  <= 8'h00;
            wr_sel   <= 1'b0;
            rd_sel   <= 1'b0;
            dbo      <= 8'h00;
            dbo_oe   <= 1'b0;
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            pos      <= next_pos;
            cnt      <= next_cnt;
            busy     <= next_busy;
            win_ctrl <= next_win_ctrl;
            win_data <= next_win_data;
            win_addr <= next_win_addr;
            mode     <= next_mode;
            cfg      <= next_cfg;
            fs       <= next_fs;
            wr_data  <= next_wr_data;
            wr_sel   <= next_wr_sel;
            rd_sel   <= next_rd_sel;
            dbo      <= next_dbo;
            dbo_oe   <= rd_act;
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
        end
    end

    assign o_db          = dbo;
    assign o_db_oe       = dbo_oe;
    assign o_mode        = mode;
    assign o_config      = cfg;
    assign o_frame_shift = fs;
    assign o_busy        = busy;

    ////////////////////////////////////////////////////////////////////////
    connection_memory u_cm
    (
        .i_clk     (i_mclk),
        .i_rst_n   (rst_n),
        .i_we      (cm_we),
        .i_addr_a  (win_addr),
        .i_wdata   ({win_ctrl[1:0], win_data}),
        .o_rdata_a (cm_q),
        .i_addr_b  (i_cm_rd_addr),
        .o_rdata_b (o_cm_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // 900 ns from strobe end, less the synchroniser cycles
    localparam int EXEC_MAX = 33;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    a_busy_first_write: assert property ( // RQ4
        (state == ira_pkg::ST_IDLE && wr_end && wr_sel && !abort) |=> busy)
        else $error("busy not set by first window write");
    a_exec_busy_clear: assert property ( // RQ5
        (state == ira_pkg::ST_COLLECT && wr_end && wr_sel && pos == ira_pkg::POS_ADDR && !abort)
        |=> busy ##[1:EXEC_MAX] !busy)
        else $error("indirect access exceeded its time");
    a_release_clear: assert property ( // RQ16
        (state == ira_pkg::ST_READBACK && rd_end && rd_sel && pos == ira_pkg::POS_ADDR && !abort)
        |=> busy ##[1:EXEC_MAX] !busy)
        else $error("release after read back too long");
    a_abort_cancel: assert property ( // RQ8
        abort |=> state == ira_pkg::ST_IDLE && pos == ira_pkg::POS_CTRL && !busy)
        else $error("abort did not cancel sequence");
    a_status_low_zero: assert property ( // RQ20
        (rd_start && sel_s == ira_pkg::SEL_DIRECT) |=> o_db[4:0] == 5'h00 && o_db[6] == $past(busy))
        else $error("status read value wrong");
    a_ctrl_unused_one: assert property ( // RQ17
        (rd_start && sel_s && pos == ira_pkg::POS_CTRL) |=> (o_db & 8'hcc) == 8'hcc)
        else $error("unused control bits not one");
    a_cfg_read_ones: assert property ( // RQ22
        (state == ira_pkg::ST_EXEC && cnt == 6'h00 && kind == 2'h3 && reg_read
         && win_addr == 8'hfe && !abort) |=> win_data[7:2] == 6'h3f)
        else $error("configuration read top bits not one");
    a_fs_standard: assert property ( // RQ21
        standard |=> o_frame_shift == 8'h00)
        else $error("frame shift not held at zero");
    a_direct_midseq: assert property ( // RQ7
        (state != ira_pkg::ST_IDLE && wr_end && !wr_sel) |=> o_mode == $past(wr_data))
        else $error("setup write lost during sequence");
    a_cm_write_word: assert property ( // RQ12
        cm_we |=> ##1 cm_q == $past({win_ctrl[1:0], win_data}, 2))
        else $error("memory word not stored");

    c_cm_write: cover property (cm_we);
    c_readback: cover property (state == ira_pkg::ST_RELEASE);
    c_abort: cover property (abort && state == ira_pkg::ST_COLLECT);
endmodule // indirect_register_access
`default_nettype wire

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    input  wire logic       i_mclk, // Device clock
    input  wire logic [7:0] i_bus,  // Resolved data bus
    output logic            o_cs_n, // Device select
    output logic            o_wr_n, // Store strobe
    output logic            o_rd_n, // Fetch strobe
    output logic            o_sel,  // Window select
    output logic      [7:0] o_db    // Host bus drive
);
    initial
    begin
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_sel  = 1'b0;
        o_db   = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    // select framing, idle gaps
    task automatic access(input logic cs_n, wr, sel, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_mclk) #2;
        o_cs_n = cs_n;
        o_sel  = sel;
        o_db   = d;
        o_wr_n = !wr;
        o_rd_n = wr;
        repeat (4) @(posedge i_mclk);
        q = i_bus;
        #2;
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        // Released bus must not keep the last byte
        o_db   = ~d;
        repeat (4) @(posedge i_mclk);
        // Return off the edge so callers never race the design's flops
        #2;
    endtask
    task automatic wait_idle(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++)
        begin
            access(1'b0, 1'b0, 1'b0, 8'h00, s);
            ok = (s[7:6] === 2'b00);
        end
    endtask
endmodule // host_model
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        i_mclk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        cs_n, wr_n, rd_n, sel, oe, busy, ok;
    logic        mrb = 1'b0;
    logic        loss = 1'b0;
    logic [7:0]  hdb, db, bus, r, mode, fs, a, d, c;
    logic [7:0]  ca = 8'h00;
    logic [1:0]  cfg;
    logic [9:0]  cw;
    logic [31:0] seed = 32'h73b06f36;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;

    always #12.5 i_mclk = ~i_mclk;
    assign bus = oe ? db : hdb;

    host_model u_host_model (.i_mclk(i_mclk), .i_bus(bus), .o_cs_n(cs_n), .o_wr_n(wr_n),
        .o_rd_n(rd_n), .o_sel(sel), .o_db(hdb));
    indirect_register_access u_indirect_register_access (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_register_select_line(sel), .i_db(bus),
        .o_db(db), .o_db_oe(oe), .i_mem_reset_busy(mrb), .i_data_loss(loss), .o_mode(mode),
        .o_config(cfg), .o_frame_shift(fs), .o_busy(busy), .i_cm_rd_addr(ca), .o_cm_word(cw));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Unused bits read as one; register kind shows ones low
    function automatic logic [7:0] rb_ctrl(input logic [7:0] k, input logic [1:0] w);
        return {2'b11, k[5:4], 2'b11, (k[5] & k[4]) ? 2'b11 : w};
    endfunction
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic rnd(output logic [7:0] v);
        seed = lfsr(seed);
        v = seed[7:0];
    endtask
    task automatic wr(input logic s, input logic [7:0] v);
        u_host_model.access(1'b0, 1'b1, s, v, r);
    endtask
    task automatic rd(input logic s, output logic [7:0] q);
        u_host_model.access(1'b0, 1'b0, s, 8'h00, q);
    endtask
    task automatic settle();
        int k;
        for (k = 0; k < 60 && busy !== 1'b0; k++)
            @(posedge i_mclk) #2;
        // Four cycles of the 900 ns pass inside the access tail
        chk(10'(k <= ira_pkg::ACCESS_CYCLES - 4), 10'h001, "busy release");
    endtask
    task automatic seq3(input logic [7:0] k, v, t);
        u_host_model.wait_idle(ok);
        chk(10'(ok), 10'h001, "idle");
        wr(1'b1, k);
        wr(1'b1, v);
        wr(1'b1, t);
        settle();
    endtask
    task automatic rd3(input logic [7:0] k, v, t);
        rd(1'b1, r);
        chk(10'(busy), 10'h001, "readback busy");
        chk(r, k, "control back");
        rd(1'b1, r);
        chk(r, v, "data back");
        rd(1'b1, r);
        chk(r, t, "address back");
        settle();
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            final_report();
        end
    end

    initial
    begin
        repeat (8) @(posedge i_mclk);
        #2 i_arst_n = 1'b1;
        repeat (8) @(posedge i_mclk);
        chk({mode, cfg}, 10'h001, "reset setup");
        chk({fs, 1'b0, busy}, 10'h000, "reset shift");
        for (int i = 0; i < 4; i++)
        begin
            {mrb, loss} = 2'(i);
            rd(1'b0, r);
            chk(r, {mrb, 1'b0, loss, 5'h00}, "flags");
        end
        {mrb, loss} = 2'b00;
        rnd(d);
        d[0] = 1'b0;
        wr(1'b0, d);
        chk(mode, d, "setup write");
        u_host_model.access(1'b1, 1'b1, 1'b0, 8'h00, r);
        chk(mode, d, "deselected");
        wr(1'b0, 8'h00);
        $display("test direct done");
        u_host_model.wait_idle(ok);
        wr(1'b1, 8'h32);
        chk(10'(busy), 10'h001, "busy set");
        rd(1'b0, r);
        chk(r, 8'h40, "flags mid");
        wr(1'b1, 8'h00);
        wr(1'b1, 8'hfe);
        settle();
        chk(cfg, 2'h0, "config");
        seq3(8'h30, 8'h55, 8'hff);
        chk(fs, 8'h55, "shift");
        seq3(8'h31, 8'h00, 8'hff);
        rd3(8'hff, 8'h55, 8'hff);
        seq3(8'h30, 8'h01, 8'h80);
        chk(cfg, 2'h0, "unmapped");
        rnd(d);
        seq3(8'h31, d, 8'hfe);
        rd3(rb_ctrl(8'h31, 2'h0), 8'hfc, 8'hfe);
        seq3(8'h30, 8'h01, 8'hfe);
        chk(fs, 8'h00, "shift held");
        $display("test register done");
        for (int i = 0; i < 6; i++)
        begin
            rnd(a);
            rnd(d);
            rnd(c);
            a = (i == 0) ? 8'hff : a;
            c = {2'b00, c[0], !c[0], 2'b00, c[2:1]};
            seq3(c, d, a);
            @(posedge i_mclk) #2 ca = a;
            repeat (2) @(posedge i_mclk);
            #2 chk(cw, {c[1:0], d}, "memory word");
            seq3(8'h00, ~d, a);
            rd3(rb_ctrl(8'h00, c[1:0]), d, a);
        end
        $display("test memory done");
        u_host_model.wait_idle(ok);
        wr(1'b1, 8'h30);
        wr(1'b0, 8'h01);
        chk(10'(busy), 10'h000, "abort");
        wr(1'b0, 8'h00);
        seq3(8'h30, 8'h00, 8'hfe);
        chk(cfg, 2'h0, "after abort");
        $display("test abort done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
